/* File: hw/vpr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// identifier and advertisement registers of the emulated phy
module vpr_regs #(
  // model number is arbitrary, not tied to any real part
  parameter logic [5:0] MODEL_NUMBER = 6'h2A
) (
  input  wire logic        ref_clk_in,      // 125 MHz device clock
  input  wire logic        rst_n_in,        // chip reset, active low
  // straps, sampled once at reset release
  input  wire logic        flow_control_manual_strap_in, // 1: no pause
  input  wire logic        fd_fc_strap_in,  // both-pause tie breaker
  // 32-bit register port, byte offsets
  input  wire logic [8:0]  csr_addr_in,     // byte offset
  input  wire logic        csr_wr_in,       // write strobe
  input  wire logic        csr_rd_in,       // read strobe
  input  wire logic [31:0] csr_wdata_in,    // write data
  output logic [31:0]      csr_rdata_out,   // read data, registered
  output logic             csr_ack_out,     // one-cycle answer
  // 16-bit management register port
  input  wire logic [4:0]  mii_idx_in,      // register index
  input  wire logic        mii_wr_in,       // write strobe
  input  wire logic        mii_rd_in,       // read strobe
  input  wire logic [15:0] mii_wdata_in,    // write data
  output logic [15:0]      mii_rdata_out,   // read data, registered
  output logic             mii_ack_out,     // one-cycle answer
  // configuration loader
  input  wire logic        reload_cmd_in,   // reload command pulse
  output logic             load_req_out,    // ask loader to rewrite
  input  wire logic        loader_wr_in,    // loader write strobe
  input  wire logic [15:0] loader_data_in,  // whole advertisement
  // emulated negotiation
  input  wire logic        an_restart_in,   // rerun negotiation
  output logic             an_done_out,     // negotiation complete
  output logic             adv_sym_out,     // advertised sym pause
  output logic             adv_asym_out,    // advertised asym pause
  output logic             lp_sym_out,      // partner sym pause
  output logic             lp_asym_out      // partner asym pause
);

  //////////////////////////////////////////////////////////////////////
  // state
  //////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [15:0] id_hi;         // upper oui bits
    logic [5:0]  oui_lo;        // lowest six oui bits
    logic [3:0]  rev;           // revision number
    logic [15:0] adv;           // advertisement, fixed bits kept 0
    logic        strap_man;     // captured manual flow strap
    logic        strap_fd;      // captured full-duplex flow strap
    logic        init_done;     // straps captured after release
    logic        an_done;       // negotiation has run
    logic        lp_sym;        // partner symmetric pause
    logic        lp_asym;       // partner asymmetric pause
    logic [31:0] csr_rdata;     // word read data
    logic        csr_ack;       // word port answer
    logic [15:0] mii_rdata;     // management read data
    logic        mii_ack;       // management port answer
    logic        load_req;      // loader request pulse
  } vpr_state_s;

  vpr_state_s s_r;              // registered state
  vpr_state_s s_nxt;            // next state
  logic       rst_sync_n;       // released reset copy

  //////////////////////////////////////////////////////////////////////
  // reset release
  //////////////////////////////////////////////////////////////////////

  vpr_rst_sync u_rst_sync (
    .clk_in    (ref_clk_in),
    .rst_n_in  (rst_n_in),
    .rst_n_out (rst_sync_n)
  );

  //////////////////////////////////////////////////////////////////////
  // helpers
  //////////////////////////////////////////////////////////////////////

  // 16-bit view of a register index; unknown index reads zero
  function automatic logic [15:0] reg_view(
    input vpr_state_s  st,
    input logic [4:0]  idx
  );
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      vpr_pkg::IDX_IDENT_HIGH: begin
        v = st.id_hi;
      end
      vpr_pkg::IDX_IDENT_LOW: begin
        v = {st.oui_lo, MODEL_NUMBER, st.rev};
      end
      vpr_pkg::IDX_ADVERT: begin
        v = st.adv & vpr_pkg::ADV_WR_MASK;
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  // byte offset to register index, 5'h1F when unmapped
  function automatic logic [4:0] csr_index(input logic [8:0] a);
    logic [4:0] i;
    i = 5'h1F;
    case (a)
      vpr_pkg::OFF_IDENT_HIGH: begin
        i = vpr_pkg::IDX_IDENT_HIGH;
      end
      vpr_pkg::OFF_IDENT_LOW: begin
        i = vpr_pkg::IDX_IDENT_LOW;
      end
      vpr_pkg::OFF_ADVERT: begin
        i = vpr_pkg::IDX_ADVERT;
      end
      default: begin
        i = 5'h1F;
      end
    endcase
    return i;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // next state
  //////////////////////////////////////////////////////////////////////

  // one host write per cycle: loader beats word port beats management port
  always_comb begin
    logic [4:0]  wr_idx;        // target of this cycle's write
    logic [15:0] wr_data;       // low half only, upper is padding
    logic        wr_en;         // a host write happens
    logic        an_run;        // negotiation evaluates now
    logic        sym;           // advertised sym pause used now
    logic        asym;          // advertised asym pause used now
    wr_idx  = 5'h1F;
    wr_data = 16'h0000;
    wr_en   = 1'b0;
    an_run  = 1'b0;
    sym     = 1'b0;
    asym    = 1'b0;
    s_nxt   = s_r;
    s_nxt.load_req = 1'b0;

    // answers and read data, one cycle after the strobe
    s_nxt.csr_ack = csr_rd_in | csr_wr_in;
    s_nxt.mii_ack = mii_rd_in | mii_wr_in;
    if (csr_rd_in) begin
      // upper half is reserved padding and reads 0
      s_nxt.csr_rdata = {16'h0000,
                         reg_view(s_r, csr_index(csr_addr_in))};
    end
    if (mii_rd_in) begin
      s_nxt.mii_rdata = reg_view(s_r, mii_idx_in);
    end

    // pick the host write
    if (csr_wr_in) begin
      wr_en   = 1'b1;
      wr_idx  = csr_index(csr_addr_in);
      wr_data = csr_wdata_in[15:0];
    end else if (mii_wr_in) begin
      wr_en   = 1'b1;
      wr_idx  = mii_idx_in;
      wr_data = mii_wdata_in;
    end

    // host write into the chosen register
    if (wr_en) begin
      case (wr_idx)
        vpr_pkg::IDX_IDENT_HIGH: begin
          s_nxt.id_hi = wr_data;
        end
        vpr_pkg::IDX_IDENT_LOW: begin
          // model number is fixed, its bits are dropped
          s_nxt.oui_lo = wr_data[vpr_pkg::OUI_LO_MSB:
                                 vpr_pkg::OUI_LO_LSB];
          s_nxt.rev    = wr_data[vpr_pkg::REV_MSB:0];
        end
        vpr_pkg::IDX_ADVERT: begin
          // selector taken as written; host keeps it at 802.3
          s_nxt.adv = wr_data & vpr_pkg::ADV_WR_MASK;
        end
        default: begin
          s_nxt.adv = s_r.adv;
        end
      endcase
    end

    // loader rewrites the whole advertisement, winning over hosts
    if (loader_wr_in) begin
      s_nxt.adv = loader_data_in & vpr_pkg::ADV_WR_MASK;
    end

    // first cycle after release: capture straps, set pause default
    if (!s_r.init_done) begin
      s_nxt.init_done = 1'b1;
      s_nxt.strap_man = flow_control_manual_strap_in;
      s_nxt.strap_fd  = fd_fc_strap_in;
      s_nxt.adv[vpr_pkg::ADV_ASYM_PAUSE] =
        ~flow_control_manual_strap_in;
      s_nxt.adv[vpr_pkg::ADV_SYM_PAUSE]  =
        ~flow_control_manual_strap_in;
      s_nxt.load_req = 1'b1;
      an_run = 1'b1;
      sym    = ~flow_control_manual_strap_in;
      asym   = ~flow_control_manual_strap_in;
    end else begin
      if (reload_cmd_in) begin
        s_nxt.load_req = 1'b1;
      end
      // partner result moves only when negotiation reruns
      if (an_restart_in) begin
        an_run = 1'b1;
        sym    = s_r.adv[vpr_pkg::ADV_SYM_PAUSE];
        asym   = s_r.adv[vpr_pkg::ADV_ASYM_PAUSE];
      end
    end

    // emulated partner always accommodates the advertisement
    if (an_run) begin
      s_nxt.an_done = 1'b1;
      case ({sym, asym})
        2'b00: begin
          s_nxt.lp_sym  = 1'b0;
          s_nxt.lp_asym = 1'b0;
        end
        2'b10: begin
          s_nxt.lp_sym  = 1'b1;
          s_nxt.lp_asym = 1'b0;
        end
        2'b01: begin
          s_nxt.lp_sym  = 1'b1;
          s_nxt.lp_asym = 1'b1;
        end
        default: begin
          // both advertised: full-duplex strap picks the flavour
          s_nxt.lp_sym  = s_r.init_done ? s_r.strap_fd
                                        : fd_fc_strap_in;
          s_nxt.lp_asym = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  //////////////////////////////////////////////////////////////////////

  // reset loads constants only; straps enter after release
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r        <= '0;
      s_r.id_hi  <= vpr_pkg::ID_HI_RST;
      s_r.oui_lo <= vpr_pkg::OUI_LO_RST;
      s_r.rev    <= vpr_pkg::REV_RST;
      s_r.adv    <= vpr_pkg::ADV_RST_BASE;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  //////////////////////////////////////////////////////////////////////

  assign csr_rdata_out = s_r.csr_rdata;
  assign csr_ack_out   = s_r.csr_ack;
  assign mii_rdata_out = s_r.mii_rdata;
  assign mii_ack_out   = s_r.mii_ack;
  assign load_req_out  = s_r.load_req;
  assign an_done_out   = s_r.an_done;
  assign adv_sym_out   = s_r.adv[vpr_pkg::ADV_SYM_PAUSE];
  assign adv_asym_out  = s_r.adv[vpr_pkg::ADV_ASYM_PAUSE];
  assign lp_sym_out    = s_r.lp_sym;
  assign lp_asym_out   = s_r.lp_asym;

  //////////////////////////////////////////////////////////////////////
  // checks
  //////////////////////////////////////////////////////////////////////

  // padding half of a word read is always zero
  a_word_upper_zero:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      csr_ack_out |-> csr_rdata_out[31:16] == 16'h0000)
    else $error("upper half of word read not zero");

  // a word write to the high identifier lands next cycle
  a_ident_high_write:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      csr_wr_in && csr_addr_in == vpr_pkg::OFF_IDENT_HIGH
      |=> s_r.id_hi == $past(csr_wdata_in[15:0]))
    else $error("high identifier write lost");

  // low identifier read answers with model and revision
  a_ident_low_read:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      mii_rd_in && mii_idx_in == vpr_pkg::IDX_IDENT_LOW
      |=> mii_ack_out && mii_rdata_out[9:4] == MODEL_NUMBER
          && mii_rdata_out[3:0] == $past(s_r.rev))
    else $error("low identifier read wrong");

  // loader write replaces the advertisement in one cycle
  a_loader_rewrite:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      loader_wr_in |=>
        s_r.adv == ($past(loader_data_in) & vpr_pkg::ADV_WR_MASK))
    else $error("loader did not rewrite advertisement");

  // loader is asked in the same cycle the straps are captured
  a_loader_request:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      $rose(s_r.init_done) |-> load_req_out ##1 !load_req_out)
    else $error("loader request not a single pulse");

  // next page never advertised
  a_next_page_zero:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      !s_r.adv[vpr_pkg::ADV_NEXT_PAGE])
    else $error("next page bit set");

  // remote fault and reserved bits stay clear
  a_fault_bits_zero:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      s_r.adv[15:12] == {1'b0, 1'b0, 1'b0, 1'b0} ||
      s_r.adv[vpr_pkg::ADV_REM_FAULT] == 1'b0 && !s_r.adv[14]
      && !s_r.adv[12])
    else $error("remote fault or reserved bit set");

  // 100BASE-T4 never advertised; the high identifier uses bit 9 freely, the low one holds a model bit there
  a_t4_bit_zero:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      mii_rd_in && mii_idx_in == vpr_pkg::IDX_ADVERT
      |=> !mii_rdata_out[vpr_pkg::ADV_T4])
    else $error("t4 bit read as one");

  // pause defaults follow the captured manual strap
  a_pause_default:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      $rose(s_r.init_done) && !$past(loader_wr_in) |->
        adv_sym_out == !s_r.strap_man
        && adv_asym_out == !s_r.strap_man)
    else $error("pause default does not follow strap");

  // partner result holds without a rerun
  a_partner_holds:
    assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      s_r.init_done && !an_restart_in
      |=> $stable(lp_sym_out) && $stable(lp_asym_out))
    else $error("partner pause moved without negotiation");
endmodule
`default_nettype wire

/* File: hw/vpr_rst_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-stage release of an asynchronous active-low reset
module vpr_rst_sync (
  input  wire logic clk_in,     // device clock
  input  wire logic rst_n_in,   // raw reset, active low
  output logic      rst_n_out   // reset released on clock
);
  typedef struct packed {
    logic meta;                 // first stage, read by stage two only
    logic sync;                 // second stage, drives the output
  } vpr_sync_s;

  vpr_sync_s s_r;               // registered state
  vpr_sync_s s_nxt;             // next state

  // shift a one in after the release
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = 1'b1;
    s_nxt.sync = s_r.meta;
  end

  // assertion clears both stages at once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rst_n_out = s_r.sync;
endmodule
`default_nettype wire

/* File: inc/vpr_pkg.sv */
// What this block does
// - 32-bit words, upper half reserved, MII 16-bit
// - id high bits 15:0 read/write, reset zero
// - id low bits 15:10 oui read/write, zero
// - id low bits 9:4 hold model number
// - id low bits 3:0 revision read/write
// - id low 1CCh/index 3, advert 1D0h/4
// - loader rewrites advert after reset, reload
// - advert bit 15 next page reads 0
// - bit 13 reads 0; 14, 12 reserved
// - bits 11, 10 pause advert read/write
// - pause bits reset 1 if strap low
// - straps captured when chip reset releases
// - advert bit 9 reads 0
// - bits 8:5 read/write, reset to one
// - selector bits 4:0 read/write, reset 00001b
// - advert changes wait for renegotiation
`default_nettype none
package vpr_pkg;
  // byte offsets on the 32-bit register port
  localparam logic [8:0] OFF_IDENT_HIGH = 9'h1C8;
  localparam logic [8:0] OFF_IDENT_LOW  = 9'h1CC;
  localparam logic [8:0] OFF_ADVERT     = 9'h1D0;
  // register indices on the management port
  localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENT_LOW  = 5'h03;
  localparam logic [4:0] IDX_ADVERT     = 5'h04;
  // field positions inside the low identifier
  localparam int OUI_LO_MSB = 15;
  localparam int OUI_LO_LSB = 10;
  localparam int MODEL_MSB  = 9;
  localparam int MODEL_LSB  = 4;
  localparam int REV_MSB    = 3;
  // advertisement bit positions
  localparam int ADV_NEXT_PAGE  = 15;
  localparam int ADV_REM_FAULT  = 13;
  localparam int ADV_ASYM_PAUSE = 11;
  localparam int ADV_SYM_PAUSE  = 10;
  localparam int ADV_T4         = 9;
  // writable bits of the advertisement: 11, 10, 8:0 less 9
  localparam logic [15:0] ADV_WR_MASK  = 16'h0DFF;
  // abilities and selector after reset, pause bits cleared
  localparam logic [15:0] ADV_RST_BASE = 16'h01E1;
  localparam logic [15:0] ID_HI_RST    = 16'h0000;
  localparam logic [5:0]  OUI_LO_RST   = 6'h00;
  localparam logic [3:0]  REV_RST      = 4'h0;
  // selector code for the only supported message type
  localparam logic [4:0]  SEL_IEEE8023 = 5'h01;
endpackage
`default_nettype wire

/* File: test/test_virtual_phy_ident_adv_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module test_virtual_phy_ident_adv_regs;
  localparam logic [5:0] MODEL = 6'h15; // arbitrary model number
  localparam logic [8:0] OFFS [4] = '{vpr_pkg::OFF_IDENT_HIGH,
    vpr_pkg::OFF_IDENT_LOW, vpr_pkg::OFF_ADVERT, 9'h1D4};
  localparam logic [4:0] IDXS [4] = '{vpr_pkg::IDX_IDENT_HIGH,
    vpr_pkg::IDX_IDENT_LOW, vpr_pkg::IDX_ADVERT, 5'h05};
  logic        ref_clk = 1'b0;   // 125 MHz
  logic        rst_n = 1'b0;     // chip reset, active low
  logic        man_strap = 1'b0; // 1: no pause advertised
  logic        fd_strap = 1'b1;  // tie breaker for both pauses
  logic [8:0]  csr_addr = 9'h000;
  logic        csr_wr = 1'b0;
  logic        csr_rd = 1'b0;
  logic [31:0] csr_wdata = 32'h00000000;
  logic [31:0] csr_rdata;
  logic        csr_ack;
  logic [4:0]  mii_idx;
  logic        mii_wr;
  logic        mii_rd;
  logic [15:0] mii_wdata;
  logic [15:0] mii_rdata;
  logic        mii_ack;
  logic        reload = 1'b0;
  logic        load_req;
  logic        ldr_wr = 1'b0;
  logic [15:0] ldr_data = 16'h0000;
  logic        an_restart = 1'b0;
  logic        an_done;
  logic        adv_sym;
  logic        adv_asym;
  logic        lp_sym;
  logic        lp_asym;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_req = 0;       // loader requests seen
  int unsigned seed;
  logic [15:0] img [3];         // expected register images
  always #4 ref_clk = ~ref_clk;
  vpr_regs #(.MODEL_NUMBER(MODEL)) dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .flow_control_manual_strap_in(man_strap), .fd_fc_strap_in(fd_strap),
    .csr_addr_in(csr_addr), .csr_wr_in(csr_wr), .csr_rd_in(csr_rd),
    .csr_wdata_in(csr_wdata), .csr_rdata_out(csr_rdata),
    .csr_ack_out(csr_ack), .mii_idx_in(mii_idx), .mii_wr_in(mii_wr),
    .mii_rd_in(mii_rd), .mii_wdata_in(mii_wdata),
    .mii_rdata_out(mii_rdata), .mii_ack_out(mii_ack),
    .reload_cmd_in(reload), .load_req_out(load_req),
    .loader_wr_in(ldr_wr), .loader_data_in(ldr_data),
    .an_restart_in(an_restart), .an_done_out(an_done),
    .adv_sym_out(adv_sym), .adv_asym_out(adv_asym),
    .lp_sym_out(lp_sym), .lp_asym_out(lp_asym));
  vpr_host_model host (
    .clk_in(ref_clk), .idx_out(mii_idx), .wr_out(mii_wr),
    .rd_out(mii_rd), .wdata_out(mii_wdata), .rdata_in(mii_rdata),
    .ack_in(mii_ack));
  // the loader request is a one-cycle pulse, so count them
  always @(posedge ref_clk) if (load_req === 1'b1) n_req <= n_req + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // partner result: the emulated partner accommodates our request
  function automatic logic [1:0] lp_exp(logic s, logic a, logic fd);
    return a ? {s ? fd : 1'b1, 1'b1} : {s, 1'b0};
  endfunction
  // what a register reads back after a write of d
  function automatic logic [15:0] wr_img(int i, logic [15:0] d);
    if (i == 1) return {d[15:10], MODEL, d[3:0]};
    if (i == 2) return d & vpr_pkg::ADV_WR_MASK;
    return d;
  endfunction
  task automatic csr_acc(logic wr, logic [8:0] a, logic [31:0] d,
                         output logic [31:0] q);
    @(posedge ref_clk);
    csr_addr <= a;
    csr_wr <= wr;
    csr_rd <= !wr;
    csr_wdata <= d;
    @(posedge ref_clk);
    csr_wr <= 1'b0;
    csr_rd <= 1'b0;
    csr_wdata <= ~d;
    #1;
    q = csr_rdata;
    chk("csr ack", 32'(csr_ack), 32'h1);
  endtask
  // every place read both ways, plus the advertised pause outputs
  task automatic check_all();
    logic [31:0] q;
    logic [15:0] m;
    logic        ok;
    for (int i = 0; i < 4; i++) begin
      csr_acc(1'b0, OFFS[i], 32'h0, q);
      chk("csr read", q, {16'h0000, (i < 3) ? img[i] : 16'h0000});
      host.access(1'b0, IDXS[i], 16'h0000, m, ok);
      chk("mii read", {15'h0, ok, m},
          {15'h0, 1'b1, (i < 3) ? img[i] : 16'h0});
    end
    chk("adv pause", 32'({adv_asym, adv_sym}), 32'(img[2][11:10]));
  endtask
  // straps sampled at release, loader asked once, negotiation run
  task automatic do_reset(logic man, logic fd);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    man_strap <= man;
    fd_strap <= fd;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    n_req = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("load req count", 32'(n_req), 32'h1);
    chk("an done", 32'(an_done), 32'h1);
    img[0] = vpr_pkg::ID_HI_RST;
    img[1] = {vpr_pkg::OUI_LO_RST, MODEL, vpr_pkg::REV_RST};
    img[2] = vpr_pkg::ADV_RST_BASE | (man ? 16'h0000 : 16'h0C00);
    check_all();
  endtask
  // random writes both ways, all-ones and all-zero corners first
  task automatic rw_all();
    logic [31:0] w;
    logic [31:0] q;
    logic [15:0] m;
    logic        ok;
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 3; i++) begin
        w = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom;
        if (i == 2) w[4:0] = vpr_pkg::SEL_IEEE8023;
        if (k[0]) csr_acc(1'b1, OFFS[i], w, q);
        else host.access(1'b1, IDXS[i], w[15:0], m, ok);
        img[i] = wr_img(i, w[15:0]);
      end
      csr_acc(1'b1, OFFS[3], 32'hFFFFFFFF, q);
      host.access(1'b1, IDXS[3], 16'hFFFF, m, ok);
      check_all();
    end
  endtask
  // every pause combination, then a write that must not move the result
  task automatic neg_all();
    logic [31:0] q;
    for (int c = 0; c < 4; c++) begin
      img[2][11:10] = c[1:0];
      img[2][4:0] = vpr_pkg::SEL_IEEE8023;
      csr_acc(1'b1, vpr_pkg::OFF_ADVERT, {16'h0000, img[2]}, q);
      @(posedge ref_clk);
      an_restart <= 1'b1;
      @(posedge ref_clk);
      an_restart <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("lp pause", 32'({lp_sym, lp_asym}),
          32'(lp_exp(c[0], c[1], fd_strap)));
      img[2][11:10] = ~c[1:0];
      csr_acc(1'b1, vpr_pkg::OFF_ADVERT, {16'h0000, img[2]}, q);
      chk("lp held", 32'({lp_sym, lp_asym}),
          32'(lp_exp(c[0], c[1], fd_strap)));
    end
    check_all();
  endtask
  // reload command asks the loader, which rewrites the whole register
  task automatic loader_chk();
    int k;
    logic [15:0] d;
    k = n_req;
    d = 16'($urandom);
    d[4:0] = vpr_pkg::SEL_IEEE8023;
    @(posedge ref_clk);
    reload <= 1'b1;
    @(posedge ref_clk);
    reload <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("reload req", 32'(n_req), 32'(k + 1));
    @(posedge ref_clk);
    ldr_wr <= 1'b1;
    ldr_data <= d;
    @(posedge ref_clk);
    ldr_wr <= 1'b0;
    ldr_data <= ~d;
    img[2] = d & vpr_pkg::ADV_WR_MASK;
    check_all();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'h844A854E);
    do_reset(1'b0, 1'b1);
    neg_all();
    rw_all();
    loader_chk();
    do_reset(1'b1, 1'b0);
    man_strap <= 1'b0; // strap moves after capture and must not count
    check_all();
    neg_all();
    loader_chk();
    rw_all();
    results();
  end
  // a hang ends the run well past the few hundred cycles it needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("Error watchdog expected done seen hang");
    results();
  end
endmodule
`default_nettype wire

/* File: test/vpr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// management host: one 16-bit access at a time on the index port
module vpr_host_model (
  input  wire logic        clk_in,    // device clock
  output logic [4:0]       idx_out,   // register index
  output logic             wr_out,    // write strobe
  output logic             rd_out,    // read strobe
  output logic [15:0]      wdata_out, // write data
  input  wire logic [15:0] rdata_in,  // read data
  input  wire logic        ack_in     // one-cycle answer
);
  // idle values; released index and data lines show the inverse of what was driven
  initial begin
    idx_out = 5'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // one pulse strobe, answer taken the cycle after as a 16-bit value
  task automatic access(input logic wr, input logic [4:0] idx,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ok);
    logic [15:0] dd;
    dd = d;
    // a real host only ever sends the one supported message type
    if (wr && idx == vpr_pkg::IDX_ADVERT)
      dd[4:0] = vpr_pkg::SEL_IEEE8023;
    @(posedge clk_in);
    idx_out <= idx;
    wr_out <= wr;
    rd_out <= !wr;
    wdata_out <= dd;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~dd;
    idx_out <= ~idx;
    #1;
    ok = ack_in;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire
